// ---- sim/sfrep_flash_model.sv ----
// Behavioural serial flash that answers the host controller in the bench
`timescale 1ns/100ps
module sfrep_flash_model #(
  parameter logic [7:0] ID0   = 8'h5c, // Identity values are arbitrary
  parameter logic [7:0] ID1   = 8'h3e,
  parameter logic [7:0] ID2   = 8'h71,
  parameter int         ABITS = 22
) (
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic [3:0] line,
  input  wire logic       quad_mode,
  input  wire logic       wp_en,
  output logic      [3:0] dev_out,
  output logic      [3:0] dev_oe,
  output logic            rule_err
);
  localparam int MASK = (1 << ABITS) - 1;
  logic [7:0]  mem [int];
  logic [7:0]  pq [$];
  logic [7:0]  opc, l0;
  logic [31:0] v;
  logic        armed, wel;
  int          busy_n, nclk, adr;

  function automatic int blk_size(input int a);
    if (a < 'h8000 || a >= MASK + 1 - 'h8000) return 'h2000;
    if (a < 'h10000 || a >= MASK + 1 - 'h10000) return 'h8000;
    return 'h10000;
  endfunction : blk_size

  function automatic logic prot(input int a);
    return wp_en && (a >> 16) == 1;
  endfunction : prot

  function automatic logic [7:0] rdm(input int a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rdm

  task automatic rx(input int w, input int n);
    repeat (n) begin
      @(posedge sck);
      nclk++;
      l0 = {l0[6:0], line[0]};
      v = (v << w) | 32'(w == 1 ? line[0] : w == 2 ? line[1:0] : line);
    end
  endtask : rx

  // data on falling edges, high part first
  task automatic tx(input int w, input logic [7:0] b);
    logic [7:0] s;
    for (int i = 8 - w; i >= 0; i -= w) begin
      @(negedge sck);
      s = b >> i;
      dev_oe = w == 1 ? 4'h2 : w == 2 ? 4'h3 : 4'hf;
      dev_out = w == 1 ? {2'b00, s[0], 1'b0} : s[3:0];
    end
  endtask : tx

  // address advances and wraps at the top
  task automatic stream(input int w, input int a, input logic par);
    forever begin
      tx(w, par ? 8'(a) ^ 8'h5a : rdm(a));
      a = (a + 1) & MASK;
    end
  endtask : stream

  task automatic body();
    // armed frame starts with address, else opcode
    if (armed) opc = 8'hbb;
    else begin
      if (quad_mode) rx(4, 2);
      else rx(1, 8);
      opc = v[7:0];
    end
    case (opc)
      8'h3b, 8'h5a: begin
        rx(1, 32);
        stream(opc == 8'h3b ? 2 : 1, v[31:8] & MASK, opc == 8'h5a);
      end
      // address and mode on two lines, no dummy
      8'hbb: begin
        rx(2, 16);
        armed = v[7:4] == 4'ha;
        stream(2, v[31:8] & MASK, 1'b0);
      end
      8'h9f: forever begin tx(1, ID0); tx(1, ID1); tx(1, ID2); end
      8'haf: begin
        rx(4, 2);
        forever begin tx(4, ID0); tx(4, ID1); tx(4, ID2); end
      end
      8'h05: forever tx(1, {7'h00, busy_n > 0});
      8'h20, 8'hd8: begin rx(1, 24); adr = v[23:0] & MASK; end
      8'h02: begin
        rx(1, 24);
        adr = v[23:0] & MASK;
        forever begin rx(1, 8); pq.push_back(v[7:0]); end
      end
      default: ;
    endcase
  endtask : body

  task automatic commit();
    int   base, sz;
    logic wr_cmd;
    wr_cmd = opc inside {8'h20, 8'hd8, 8'hc7, 8'h02};
    if (opc == 8'hbb && nclk == 8 && l0 == 8'hff) armed = 1'b0;
    if (opc == 8'h05 && busy_n > 0) busy_n--;
    // write enable first, never while busy
    if (wr_cmd && (!wel || busy_n > 0)) rule_err = 1'b1;
    else if (wr_cmd) begin
      sz = opc == 8'h20 ? 'h1000 : blk_size(adr);
      base = adr & ~(sz - 1);
      busy_n = 2;
      // chip erase refused when anything is protected
      if (opc == 8'hc7 && !wp_en) mem.delete();
      if ((opc == 8'h20 || opc == 8'hd8) && !prot(base))
        for (int i = 0; i < sz; i++) mem.delete(base + i);
      // whole bytes, last 256 kept, wrap in page
      if (opc == 8'h02 && !prot(adr))
        foreach (pq[i]) begin
          if (i + 256 < pq.size()) continue;
          base = (adr & ~'hff) | ((adr + i) & 'hff);
          if (rdm(base) != 8'hff) rule_err = 1'b1;
          mem[base] = pq[i];
        end
    end
    if (wr_cmd) wel = 1'b0;
    if (opc == 8'h06 && nclk == 8) wel = 1'b1;
  endtask : commit

  initial begin
    dev_oe = 4'h0;
    dev_out = 4'h0;
    {armed, wel, rule_err, busy_n, opc} = '0;
    forever begin
      @(negedge cs_n);
      {nclk, v, opc} = '0;
      pq.delete();
      fork
        body();
        @(posedge cs_n);
      join_any
      disable fork;
      dev_oe = 4'h0;
      commit();
    end
  end
endmodule : sfrep_flash_model

// ---- sim/tb_sfrep_host.sv ----
// Self-checking bench for the serial flash host controller
`timescale 1ns/100ps
module tb_sfrep_host;
  localparam int MASK = 'h3fffff;
  localparam logic [7:0] ID0 = 8'h5c; // Arbitrary identity values
  localparam logic [7:0] ID1 = 8'h3e;
  localparam logic [7:0] ID2 = 8'h71;
  logic                   sys_clk, rst, req_valid, wr_valid, tgl;
  logic                   quad_mode, wp_en, req_ready, wr_ready, rd_valid;
  logic                   done, busy, cont_active, cs_n, sck, rule_err;
  logic [7:0]             wr_data, rd_data;
  logic [3:0]             line, dev_out, dev_oe;
  sfrep_pkg::sfrep_req_t  req;
  sfrep_pkg::sfrep_pins_t sio;
  logic [7:0]             shadow [int];
  logic [7:0]             pdata [300];
  logic [7:0]             rq [$];
  logic [7:0]             ids [3] = '{ID0, ID1, ID2};
  int                     errors, comparisons, pidx;

  sfrep_host #(.SCK_HALF(2), .CS_GAP(2)) dut (
    .sys_clk(sys_clk), .rst(rst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .done(done), .busy(busy), .cont_active(cont_active), .cs_n(cs_n),
    .sck(sck), .sio_in(line), .sio(sio));

  sfrep_flash_model #(.ID0(ID0), .ID1(ID1), .ID2(ID2)) mdl (
    .cs_n(cs_n), .sck(sck), .line(line), .quad_mode(quad_mode),
    .wp_en(wp_en), .dev_out(dev_out), .dev_oe(dev_oe),
    .rule_err(rule_err));

  // Undriven lines wander every cycle
  assign line = (sio.oe & sio.dout) | (~sio.oe & dev_oe & dev_out)
              | (~sio.oe & ~dev_oe & {4{tgl}});

  always @(posedge sys_clk) begin
    tgl <= ~tgl;
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (wr_ready === 1'b1) pidx = pidx + 1;
    // A raised byte offer stands until the host takes it
    if (wr_ready === 1'b1 || wr_valid !== 1'b1)
      wr_valid <= ($urandom % 4) != 0;
    wr_data <= pdata[pidx];
  end

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic results();
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic cmp(input logic [7:0] got, input logic [7:0] ex);
    comparisons++;
    if (got !== ex) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, ex);
    end
  endtask : cmp

  function automatic logic [7:0] sh(input int a);
    return shadow.exists(a & MASK) ? shadow[a & MASK] : 8'hff;
  endfunction : sh

  task automatic op(input sfrep_pkg::sfrep_kind_t k, input int a,
                    input logic [7:0] m, input int n);
    int t;
    rq.delete();
    pidx = 0;
    req <= '{kind: k, addr: 24'(a), mode: m, len: 16'(n)};
    req_valid <= 1'b1;
    @(posedge sys_clk);
    cmp(8'(req_ready), 8'h01);
    req_valid <= 1'b0;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (done !== 1'b1 && t < 40000);
    if (t >= 40000) begin
      errors++;
      $display("BAD %0t no completion", $time);
      results();
    end else cmp(8'(busy), 8'h00);
  endtask : op

  task automatic rd(input sfrep_pkg::sfrep_kind_t k, input int a,
                    input logic [7:0] m, input int n);
    logic [7:0] ex;
    op(k, a, m, n);
    cmp(8'(rq.size()), 8'(n));
    foreach (rq[i]) begin
      if (k == sfrep_pkg::K_ID || k == sfrep_pkg::K_QUAD_ID) ex = ids[i % 3];
      else if (k == sfrep_pkg::K_PARAM) ex = 8'(a + i) ^ 8'h5a;
      else ex = sh(a + i);
      cmp(rq[i], ex);
    end
  endtask : rd

  task automatic prog(input int a, input int n);
    foreach (pdata[i]) pdata[i] = 8'($urandom);
    op(sfrep_pkg::K_PROG, a, 8'h00, n);
    if (!(wp_en && (a >> 16) == 1))
      for (int i = 0; i < n; i++)
        shadow[(a & ~'hff) | ((a + i) & 'hff)] = pdata[i];
  endtask : prog

  task automatic ers(input sfrep_pkg::sfrep_kind_t k, input int a);
    int sz;
    op(k, a, 8'h00, 1);
    sz = k == sfrep_pkg::K_SECT ? 'h1000 : mdl.blk_size(a);
    if (k == sfrep_pkg::K_CHIP && !wp_en) shadow.delete();
    if (k != sfrep_pkg::K_CHIP && !(wp_en && (a >> 16) == 1))
      for (int i = 0; i < sz; i++) shadow.delete((a & ~(sz - 1)) + i);
  endtask : ers

  initial begin
    {errors, comparisons, pidx, tgl, req, req_valid} = '0;
    {wr_valid, wr_data, quad_mode, wp_en} = '0;
    rst = 1'b1;
    void'($urandom(76));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    ers(sfrep_pkg::K_CHIP, 0);
    prog('h0000f8, 260);
    prog('h3ffff0, 16);
    prog('h010200, 8);
    for (int t = 0; t < 3; t++)
      prog('h200000 + t * 'h1000 + $urandom % 'h100, 1 + $urandom % 24);
    rd(sfrep_pkg::K_DUAL_OUT, 'h0000f0, 8'h00, 24);
    rd(sfrep_pkg::K_DUAL_OUT, 'h3ffffc, 8'h00, 8);
    for (int t = 0; t < 3; t++)
      rd(sfrep_pkg::K_DUAL_OUT, 'h200000 + t * 'h1000, 0, 1 + $urandom % 40);
    rd(sfrep_pkg::K_PARAM, $urandom & MASK, 8'h00, 5);
    rd(sfrep_pkg::K_DUAL_IO, 'h0000fe, 8'ha5, 6);
    cmp(8'(cont_active), 8'h01);
    rd(sfrep_pkg::K_DUAL_IO, 'h3ffffe, 8'h30, 4);
    cmp(8'(cont_active), 8'h00);
    rd(sfrep_pkg::K_ID, 0, 8'h00, 3);
    rd(sfrep_pkg::K_DUAL_IO, 'h200000, 8'ha0, 4);
    rd(sfrep_pkg::K_ID, 0, 8'h00, 3);
    rd(sfrep_pkg::K_DUAL_IO, 'h0000f8, 8'haf, 3);
    op(sfrep_pkg::K_EXIT, 0, 8'h00, 1);
    cmp(8'(cont_active), 8'h00);
    rd(sfrep_pkg::K_DUAL_OUT, 'h0000f8, 8'h00, 4);
    quad_mode <= 1'b1;
    rd(sfrep_pkg::K_QUAD_ID, 0, 8'h00, 3);
    quad_mode <= 1'b0;
    ers(sfrep_pkg::K_SECT, 'h000abc);
    rd(sfrep_pkg::K_DUAL_OUT, 'h0000f0, 8'h00, 24);
    prog('h3fe010, 4);
    prog('h00f000, 4);
    ers(sfrep_pkg::K_BLOCK, 'h3ff123);
    ers(sfrep_pkg::K_BLOCK, 'h00a000);
    ers(sfrep_pkg::K_BLOCK, 'h20abcd);
    rd(sfrep_pkg::K_DUAL_OUT, 'h3fe00c, 8'h00, 8);
    rd(sfrep_pkg::K_DUAL_OUT, 'h00effe, 8'h00, 8);
    rd(sfrep_pkg::K_DUAL_OUT, 'h201000, 8'h00, 32);
    wp_en <= 1'b1;
    prog('h010300, 4);
    ers(sfrep_pkg::K_SECT, 'h010200);
    ers(sfrep_pkg::K_BLOCK, 'h01ffff);
    ers(sfrep_pkg::K_CHIP, 0);
    rd(sfrep_pkg::K_DUAL_OUT, 'h0101fc, 8'h00, 12);
    wp_en <= 1'b0;
    cmp(8'(rule_err), 8'h00);
    results();
  end
endmodule : tb_sfrep_host

// ---- src/sfrep_host.sv ----
// Host controller issuing read, identify, erase and program frames to a flash
`timescale 1ns/100ps
// Summary of operation
// - Dual-output read: 3BH, 24-bit address, dummy byte, data on two lines.
// - Chip select stays low for the whole read; rising ends it.
// - Dual I/O read: BBH, then address and mode two bits per clock.
// - Mode nibble A arms next dual I/O read without opcode.
// - Opcode FFH leaves continuation mode.
// - Quad cycles carry one nibble, most significant nibble first.
// - Parameter read: 5AH, 24-bit address, dummy byte, then table data.
// - Write enable precedes every erase or program command.
// - Erase and program are self-timed; completion by polling busy.
// - Page program: 02H, address, 1 to 256 whole bytes; the host sends len bytes (at least one) with no 256 limit.
// - Host programs only locations already erased to FFH.
module sfrep_host #(
  parameter int SCK_HALF = sfrep_pkg::SCK_HALF_CYC,
  parameter int CS_GAP   = sfrep_pkg::CS_GAP_CYC
) (
  input  logic                   sys_clk,
  input  logic                   rst,
  input  sfrep_pkg::sfrep_req_t  req,
  input  logic                   req_valid,
  output logic                   req_ready,
  input  logic [7:0]             wr_data,
  input  logic                   wr_valid,
  output logic                   wr_ready,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output logic                   done,
  output logic                   busy,
  output logic                   cont_active,
  output logic                   cs_n,
  output logic                   sck,
  input  logic [3:0]             sio_in,
  output sfrep_pkg::sfrep_pins_t sio
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LEAD  = 3'b001,
    ST_SHIFT = 3'b011,
    ST_TAIL  = 3'b010,
    ST_GAP   = 3'b110
  } sfrep_st_t;
  typedef enum logic [1:0] {
    FR_EXIT = 2'b00,
    FR_WRITE_ENABLE_CMD = 2'b01,
    FR_MAIN = 2'b11,
    FR_POLL = 2'b10
  } sfrep_fr_t;
  typedef enum logic [2:0] {
    PH_OPC   = 3'b000,
    PH_ADDR  = 3'b001,
    PH_MODE  = 3'b011,
    PH_READ  = 3'b111,
    PH_DUMMY = 3'b010,
    PH_WRITE = 3'b110
  } sfrep_ph_t;

  localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);
  localparam logic [7:0] GAP_M1  = 8'(CS_GAP - 1);

  sfrep_st_t             st_q;
  sfrep_fr_t             fr_q;
  sfrep_fr_t             sfr_w;
  sfrep_fr_t             nfr_w;
  sfrep_ph_t             ph_q;
  sfrep_ph_t             nph_w;
  sfrep_pkg::sfrep_req_t r_q;
  sfrep_pkg::sfrep_pins_t pins_d;
  logic [7:0]  tx_q, tx_ld_w, tx_sh_w, opc_w, rx_q, rx_nx_w, div_q;
  logic [7:0]  rd_data_q;
  logic [15:0] lft_q;
  logic [2:0]  beat_q, last_beat_w;
  logic [1:0]  cnt_q, wid_w;
  logic [3:0]  sio_s;
  logic sck_q, ld_q, cont_q, busy_q, write_enable_cmd_seen_q, rd_valid_q, done_q;
  logic cs_n_q, fin_w, div_end_w, tick_w, fall_w, byte_end_w, stall_w;
  logic load_w, wr_kind_w, req_wr_w, idle_w, drv_w, gap_end_w, sel_w;

  sfrep_sync #(.WIDTH(4)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     (sio_in),
    .dout    (sio_s)
  );

  function automatic logic is_write(sfrep_pkg::sfrep_kind_t k);
    return k inside {sfrep_pkg::K_SECT, sfrep_pkg::K_BLOCK,
                     sfrep_pkg::K_CHIP, sfrep_pkg::K_PROG};
  endfunction : is_write

  assign wr_kind_w = is_write(r_q.kind);
  assign req_wr_w  = is_write(req.kind);

  // exit continuation before any other command
  assign sfr_w = (req.kind == sfrep_pkg::K_EXIT ||
                  (cont_q && req.kind != sfrep_pkg::K_DUAL_IO)) ? FR_EXIT :
                 // write enable ahead of erase or program
                 req_wr_w ? FR_WRITE_ENABLE_CMD : FR_MAIN;
  // poll busy until the self-timed operation ends
  assign nfr_w = (fr_q == FR_EXIT) ? (wr_kind_w ? FR_WRITE_ENABLE_CMD : FR_MAIN) :
                 (fr_q == FR_WRITE_ENABLE_CMD) ? FR_MAIN : FR_POLL;
  // no return to idle while the busy bit is still set
  assign idle_w = (fr_q == FR_EXIT && r_q.kind == sfrep_pkg::K_EXIT) ||
                  (fr_q == FR_MAIN && !wr_kind_w) ||
                  (fr_q == FR_POLL && !busy_q);

  assign opc_w =
    (r_q.kind == sfrep_pkg::K_DUAL_OUT) ? sfrep_pkg::OP_DUAL_OUT :
    (r_q.kind == sfrep_pkg::K_DUAL_IO)  ? sfrep_pkg::OP_DUAL_IO :
    (r_q.kind == sfrep_pkg::K_ID)       ? sfrep_pkg::OP_ID :
    (r_q.kind == sfrep_pkg::K_QUAD_ID)  ? sfrep_pkg::OP_QUAD_ID :
    (r_q.kind == sfrep_pkg::K_PARAM)    ? sfrep_pkg::OP_PARAM :
    (r_q.kind == sfrep_pkg::K_SECT)     ? sfrep_pkg::OP_SECT :
    (r_q.kind == sfrep_pkg::K_BLOCK)    ? sfrep_pkg::OP_BLOCK :
    (r_q.kind == sfrep_pkg::K_CHIP)     ? sfrep_pkg::OP_CHIP :
    sfrep_pkg::OP_PROG;

  // Lines per clock: 0 one, 1 two, 2 four
  assign wid_w =
    (fr_q == FR_MAIN && r_q.kind == sfrep_pkg::K_QUAD_ID) ? 2'd2 :
    (fr_q == FR_MAIN && r_q.kind == sfrep_pkg::K_DUAL_IO &&
     ph_q != PH_OPC) ? 2'd1 :
    (fr_q == FR_MAIN && r_q.kind == sfrep_pkg::K_DUAL_OUT &&
     ph_q == PH_READ) ? 2'd1 : 2'd0;
  assign last_beat_w = (wid_w == 2'd2) ? 3'd1 :
                       (wid_w == 2'd1) ? 3'd3 : 3'd7;

  assign div_end_w  = (div_q == 8'h00);
  assign tick_w     = (st_q == ST_SHIFT) && !ld_q && div_end_w;
  assign fall_w     = tick_w && sck_q;
  assign byte_end_w = fall_w && (beat_q == last_beat_w);
  assign stall_w    = ld_q && (ph_q == PH_WRITE) && !wr_valid;
  assign load_w     = (st_q == ST_SHIFT) && ld_q && !stall_w;
  assign gap_end_w  = (st_q == ST_GAP) && div_end_w;
  assign sel_w      = st_q inside {ST_LEAD, ST_SHIFT, ST_TAIL};

  assign tx_sh_w = (wid_w == 2'd2) ? {tx_q[3:0], 4'h0} :
                   (wid_w == 2'd1) ? {tx_q[5:0], 2'b00} : {tx_q[6:0], 1'b0};
  assign rx_nx_w = (wid_w == 2'd2) ? {rx_q[3:0], sio_s} :
                   (wid_w == 2'd1) ? {rx_q[5:0], sio_s[1:0]} :
                   {rx_q[6:0], sio_s[1]};

  assign tx_ld_w =
    (ph_q == PH_OPC) ? ((fr_q == FR_EXIT) ? sfrep_pkg::OP_EXIT :
                        (fr_q == FR_WRITE_ENABLE_CMD) ? sfrep_pkg::OP_WRITE_ENABLE_CMD :
                        (fr_q == FR_POLL) ? sfrep_pkg::OP_STATUS : opc_w) :
    (ph_q == PH_ADDR) ? ((cnt_q == 2'd2) ? r_q.addr[23:16] :
                         (cnt_q == 2'd1) ? r_q.addr[15:8] : r_q.addr[7:0]) :
    (ph_q == PH_MODE)  ? r_q.mode :
    (ph_q == PH_DUMMY) ? sfrep_pkg::DUMMY_BYTE :
    // caller program data goes out unchanged
    (ph_q == PH_WRITE) ? wr_data : sfrep_pkg::IDLE_BYTE;

  // Phase that follows a finished byte, or the end of the frame
  always_comb begin
    nph_w = ph_q;
    fin_w = 1'b0;
    unique case (ph_q)
      PH_OPC: begin
        if (fr_q == FR_EXIT || fr_q == FR_WRITE_ENABLE_CMD) fin_w = 1'b1;
        else if (fr_q == FR_POLL || r_q.kind == sfrep_pkg::K_ID) nph_w = PH_READ;
        // quad identify takes one dummy byte, two clocks on four lines
        else if (r_q.kind == sfrep_pkg::K_QUAD_ID) nph_w = PH_DUMMY;
        else if (r_q.kind == sfrep_pkg::K_CHIP) fin_w = 1'b1;
        else nph_w = PH_ADDR;
      end
      PH_ADDR: begin
        if (cnt_q != 2'd0) nph_w = PH_ADDR;
        // mode byte straight after the address
        else if (r_q.kind == sfrep_pkg::K_DUAL_IO) nph_w = PH_MODE;
        else if (r_q.kind == sfrep_pkg::K_PROG) nph_w = PH_WRITE;
        else if (wr_kind_w) fin_w = 1'b1;
        // dummy byte ahead of read data
        else nph_w = PH_DUMMY;
      end
      PH_MODE:  nph_w = PH_READ;
      PH_DUMMY: nph_w = PH_READ;
      // frame ends only on a whole byte
      PH_WRITE, PH_READ: fin_w = (lft_q == 16'h0000);
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      fr_q <= FR_MAIN;
      ph_q <= PH_OPC;
      r_q  <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: if (req_valid) begin
          st_q <= ST_LEAD;
          r_q  <= req;
          fr_q <= sfr_w;
          // armed dual I/O read starts at the address
          ph_q <= (sfr_w == FR_MAIN && req.kind == sfrep_pkg::K_DUAL_IO &&
                   cont_q) ? PH_ADDR : PH_OPC;
        end
        ST_LEAD: if (div_end_w) st_q <= ST_SHIFT;
        ST_SHIFT: begin
          // select held until the final byte is done
          if (byte_end_w && fin_w) st_q <= ST_TAIL;
          else if (byte_end_w) ph_q <= nph_w;
        end
        ST_TAIL: if (div_end_w) st_q <= ST_GAP;
        ST_GAP: if (div_end_w) begin
          st_q <= idle_w ? ST_IDLE : ST_LEAD;
          fr_q <= nfr_w;
          ph_q <= PH_OPC;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= 8'h00;
      sck_q <= 1'b0;
    end else begin
      if (st_q == ST_IDLE) div_q <= HALF_M1;
      else if (div_end_w) div_q <= (st_q == ST_TAIL) ? GAP_M1 : HALF_M1;
      else if (!(st_q == ST_SHIFT && ld_q)) div_q <= div_q - 8'h01;
      if (tick_w) sck_q <= ~sck_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ld_q   <= 1'b0;
      tx_q   <= 8'h00;
      rx_q   <= 8'h00;
      beat_q <= 3'd0;
    end else begin
      ld_q <= (st_q == ST_LEAD) || (byte_end_w && !fin_w) ||
              (ld_q && !load_w && st_q == ST_SHIFT);
      if (load_w) tx_q <= tx_ld_w;
      else if (fall_w) tx_q <= tx_sh_w;
      if (fall_w) rx_q <= rx_nx_w;
      if (load_w) beat_q <= 3'd0;
      else if (fall_w) beat_q <= byte_end_w ? 3'd0 : beat_q + 3'd1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'd0;
      lft_q <= 16'h0000;
    end else begin
      if (ph_q != PH_ADDR) cnt_q <= 2'(sfrep_pkg::ADDR_BYTES - 1);
      else if (byte_end_w) cnt_q <= cnt_q - 2'd1;
      if (!(ph_q inside {PH_WRITE, PH_READ}))
        lft_q <= (fr_q == FR_POLL || r_q.len == 16'h0000) ? 16'h0000 :
                 r_q.len - 16'h0001;
      else if (byte_end_w) lft_q <= lft_q - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cont_q      <= 1'b0;
      busy_q      <= 1'b0;
      write_enable_cmd_seen_q <= 1'b0;
    end else begin
      // mode nibble decides whether the next read is armed
      if (byte_end_w && ph_q == PH_MODE)
        cont_q <= (r_q.mode[7:4] == sfrep_pkg::CONT_NIBBLE);
      else if (byte_end_w && fr_q == FR_EXIT) cont_q <= 1'b0;
      // busy sampled from the status byte
      if (byte_end_w && fr_q == FR_POLL && ph_q == PH_READ)
        busy_q <= rx_nx_w[sfrep_pkg::BUSY_BIT];
      if (st_q == ST_IDLE) write_enable_cmd_seen_q <= 1'b0;
      else if (gap_end_w && fr_q == FR_WRITE_ENABLE_CMD) write_enable_cmd_seen_q <= 1'b1;
    end
  end

  assign drv_w = sel_w && (ph_q != PH_READ);
  always_comb begin
    unique case (wid_w)
      2'd2: pins_d = '{dout: tx_q[7:4], oe: {4{drv_w}}};
      2'd1: pins_d = '{dout: {2'b11, tx_q[7:6]}, oe: {2'b11, drv_w, drv_w}};
      default: pins_d = '{dout: {3'b111, tx_q[7]}, oe: {3'b110, drv_w}};
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sio        <= '{dout: 4'hf, oe: 4'hc};
      cs_n_q     <= 1'b1;
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      sio        <= pins_d;
      cs_n_q     <= !sel_w;
      rd_valid_q <= byte_end_w && fr_q == FR_MAIN && ph_q == PH_READ;
      if (byte_end_w && fr_q == FR_MAIN && ph_q == PH_READ)
        rd_data_q <= rx_nx_w;
      done_q     <= gap_end_w && idle_w;
    end
  end

  assign req_ready   = (st_q == ST_IDLE);
  assign wr_ready    = load_w && (ph_q == PH_WRITE);
  assign rd_data     = rd_data_q;
  assign rd_valid    = rd_valid_q;
  assign done        = done_q;
  assign busy        = busy_q;
  assign cont_active = cont_q;
  assign cs_n        = cs_n_q;
  assign sck         = sck_q;

  sequence s_mode_done;
    byte_end_w && ph_q == PH_MODE;
  endsequence
  sequence s_main_write_end;
    gap_end_w && fr_q == FR_MAIN && wr_kind_w;
  endsequence

  write_enable_cmd_first_a: assert property (@(posedge sys_clk) disable iff (rst)
    (load_w && fr_q == FR_MAIN && ph_q == PH_OPC && wr_kind_w) |-> write_enable_cmd_seen_q)
    else $error("Erase or program opcode without write enable");
  dual_opcode_a: assert property (@(posedge sys_clk) disable iff (rst)
    (load_w && fr_q == FR_MAIN && ph_q == PH_OPC &&
     r_q.kind == sfrep_pkg::K_DUAL_OUT) |=> tx_q == 8'h3b)
    else $error("Dual output read opcode wrong");
  cont_skip_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == ST_IDLE && req_valid && cont_q &&
     req.kind == sfrep_pkg::K_DUAL_IO) |=> ph_q == PH_ADDR && fr_q == FR_MAIN)
    else $error("Armed dual I/O read did not skip opcode");
  exit_first_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == ST_LEAD && fr_q == FR_MAIN && cont_q) |->
    r_q.kind == sfrep_pkg::K_DUAL_IO)
    else $error("Other command sent while continuation armed");
  no_dummy_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_mode_done |=> ph_q == PH_READ && ld_q)
    else $error("Dual I/O read data did not follow mode byte");
  cs_held_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == ST_SHIFT && ph_q == PH_READ) |=> !cs_n ##1 !cs_n)
    else $error("Select released inside a read");
  poll_after_a: assert property (@(posedge sys_clk) disable iff (rst)
    s_main_write_end |=> fr_q == FR_POLL && st_q == ST_LEAD)
    else $error("No busy poll after erase or program");
  done_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    done |-> !busy_q && st_q == ST_IDLE)
    else $error("Command finished while device busy");
  whole_byte_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(cs_n) |-> beat_q == 3'd0 && !ld_q)
    else $error("Frame ended on a partial byte");
  quad_nibble_a: assert property (@(posedge sys_clk) disable iff (rst)
    (fall_w && wid_w == 2'd2 && ph_q != PH_READ) |=> ##1
    sio.dout == $past(tx_q[3:0], 2))
    else $error("Quad low nibble not sent second");

endmodule : sfrep_host

// ---- src/sfrep_pkg.sv ----
// Shared constants and carrier types for the serial flash host controller
package sfrep_pkg;

  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO  = 8'hbb;
  localparam logic [7:0] OP_ID       = 8'h9f;
  localparam logic [7:0] OP_QUAD_ID  = 8'haf;
  localparam logic [7:0] OP_PARAM    = 8'h5a;
  localparam logic [7:0] OP_SECT     = 8'h20;
  localparam logic [7:0] OP_BLOCK    = 8'hd8;
  localparam logic [7:0] OP_CHIP     = 8'hc7;
  localparam logic [7:0] OP_PROG     = 8'h02;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD     = 8'h06;
  localparam logic [7:0] OP_STATUS   = 8'h05;
  localparam logic [7:0] OP_EXIT     = 8'hff;
  localparam logic [7:0] DUMMY_BYTE  = 8'h00;
  localparam logic [7:0] IDLE_BYTE   = 8'hff;

  // Upper nibble of the mode byte that keeps the dual I/O read armed
  localparam logic [3:0] CONT_NIBBLE = 4'ha;
  localparam int         BUSY_BIT    = 0;
  localparam int         ADDR_BYTES  = 3;
  localparam int         PAGE_BYTES  = 256;

  localparam int CLK_PERIOD_NS = 5;
  localparam int SCK_HALF_NS   = 20;
  localparam int CS_GAP_NS     = 50;
  localparam int SCK_HALF_CYC  =
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_GAP_CYC    =
    (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    K_DUAL_OUT = 4'h0,
    K_DUAL_IO  = 4'h1,
    K_ID       = 4'h2,
    K_QUAD_ID  = 4'h3,
    K_PARAM    = 4'h4,
    K_SECT     = 4'h5,
    K_BLOCK    = 4'h6,
    K_CHIP     = 4'h7,
    K_PROG     = 4'h8,
    K_EXIT     = 4'h9
  } sfrep_kind_t;

  typedef struct packed {
    sfrep_kind_t kind;
    logic [23:0] addr;
    logic [7:0]  mode;
    logic [15:0] len;
  } sfrep_req_t;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
  } sfrep_pins_t;

endpackage : sfrep_pkg

// ---- src/sfrep_sync.sv ----
// Two-stage synchroniser for the data lines coming back from the flash
`timescale 1ns/100ps
module sfrep_sync #(
  parameter int WIDTH = 4
) (
  input  logic             sys_clk,
  input  logic             rst,
  input  logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= din[i];
        sync_q <= meta_q;
      end
    end
    assign dout[i] = sync_q;
  end

endmodule : sfrep_sync
